// ### core/evpc_pkg.sv
// package: constants and types of the event pin and calibration status block
// Notes on behaviour
// - The top byte of the event register holds eight calibration flags, one meaning failed.
// - A successful calibration clears only the flags of the channels it calibrated.
// - Flag order high to low is reactive 2, reactive 1, active 2, active 1, amps 2, amps 1, volts, freq.
// - Bits 23 to 20 map over power, over current, surge and sag onto pin b when set.
// - Bits 19 to 16 map over power, over current, surge and sag onto pin a when set.
// - Under manual control pin b follows bit 15, low by default.
// - Under manual control pin a follows bit 14, low by default.
// - Bits 13 and 12 read as zero and ignore writes.
// - A one in bit 11, 10, 9 or 8 clears the over current, over power, surge or sag alarm.
// - Bits 7 and 6 make the surge and sag alarms stay latched until cleared.
// - Manual drive of a pin applies only while no alarm is mapped to it; several may be mapped.
// - An active alarm mapped to a pin drives that pin high.
// - Bits 5 and 4 make the over power and over current alarms stay latched until cleared.
// - Bits 3 to 0 force a simulated surge, sag, over power or over current alarm while set.
package evpc_pkg;
    // alarm index order used everywhere inside the block
    localparam int EVPC_NUM_ALARMS = 4;
    localparam int EVPC_ALM_DIP = 0;
    localparam int EVPC_ALM_SWELL = 1;
    localparam int EVPC_ALM_AMPS = 2;
    localparam int EVPC_ALM_POWER = 3;
    // register byte offsets
    localparam logic [7:0] EVPC_OFF_EVENT = 8'h00;
    localparam logic [7:0] EVPC_OFF_STAT = 8'h04;
    localparam logic [7:0] EVPC_OFF_MASK = 8'h08;
    localparam logic [7:0] EVPC_OFF_LIVE = 8'h0C;
    localparam int EVPC_OFF_W = 8;
    // event register field positions, indexed dip, swell, amps, power
    localparam int EVPC_CAL_LSB = 24;
    localparam int EVPC_CAL_W = 8;
    localparam int EVPC_MAP_A_POS [EVPC_NUM_ALARMS] = '{16, 17, 18, 19};
    localparam int EVPC_MAP_B_POS [EVPC_NUM_ALARMS] = '{20, 21, 22, 23};
    localparam int EVPC_MAN_B_BIT = 15;
    localparam int EVPC_MAN_A_BIT = 14;
    localparam int EVPC_CLR_POS [EVPC_NUM_ALARMS] = '{8, 9, 11, 10};
    localparam int EVPC_HOLD_POS [EVPC_NUM_ALARMS] = '{6, 7, 4, 5};
    localparam int EVPC_SIM_POS [EVPC_NUM_ALARMS] = '{2, 3, 0, 1};
    localparam logic [31:0] EVPC_EVENT_RESET = 32'h0000_0000;
    // interrupt status layout: alarm rises, then calibration outcomes
    localparam int EVPC_STAT_W = 6;
    localparam int EVPC_ST_CAL_FAIL = 4;
    localparam int EVPC_ST_CAL_PASS = 5;
    // live register layout
    localparam int EVPC_LIVE_RAW_LSB = 4;
    localparam int EVPC_LIVE_PIN_A = 8;
    localparam int EVPC_LIVE_PIN_B = 9;
    // bus constants
    localparam int EVPC_HTRANS_ACTIVE_BIT = 1;
    localparam logic [2:0] EVPC_HSIZE_WORD = 3'h2;
    localparam logic EVPC_HRESP_OKAY = 1'b0;
    localparam logic EVPC_HREADY_NOWAIT = 1'b1;

    typedef enum logic [2:0] {
        EVPC_SEL_EVENT,
        EVPC_SEL_STAT,
        EVPC_SEL_MASK,
        EVPC_SEL_LIVE,
        EVPC_SEL_NONE
    } evpc_sel_t;

    // calibration outcome reported by the calibration engine
    typedef struct packed {
        logic done;
        logic pass;
        logic [EVPC_CAL_W-1:0] chans;
    } evpc_cal_t;

    typedef struct packed {
        logic [EVPC_CAL_W-1:0] cal_fail;
        logic [EVPC_NUM_ALARMS-1:0] map_a;
        logic [EVPC_NUM_ALARMS-1:0] map_b;
        logic man_a;
        logic man_b;
        logic [EVPC_NUM_ALARMS-1:0] clr;
        logic [EVPC_NUM_ALARMS-1:0] hold;
        logic [EVPC_NUM_ALARMS-1:0] sim;
        logic [EVPC_STAT_W-1:0] stat;
        logic [EVPC_STAT_W-1:0] mask;
        logic [EVPC_NUM_ALARMS-1:0] flag_q;
        logic ph_valid;
        logic ph_write;
        evpc_sel_t ph_sel;
        logic [31:0] rdata;
        logic pin_a;
        logic pin_b;
        logic irq;
    } evpc_state_t;

    typedef struct packed {
        logic flag;
    } evpc_cell_t;
endpackage

// ### core/evpc_alarm_cell.sv
// one alarm flag with optional latching, clear and simulation
`timescale 1ns/1ps
module evpc_alarm_cell
    import evpc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic live,
    input wire logic simulate,
    input wire logic hold,
    input wire logic clear,
    output logic flag
);
    evpc_cell_t st;
    evpc_cell_t next_st;
    logic cond;

    // a forced alarm looks like a real one downstream
    assign cond = live | simulate;

    // set wins over clear so a new alarm is never lost
    always_comb begin
        next_st = st;
        if (hold) begin
            next_st.flag = cond | (st.flag & ~clear);
        end else begin
            next_st.flag = cond;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign flag = st.flag;
endmodule

// ### core/evpc_event_ctrl.sv
// event pin routing, calibration status and AHB-Lite register slave
//
// Local design decisions: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
module evpc_event_ctrl
    import evpc_pkg::*;
#(
    parameter int NUM_ALARMS = EVPC_NUM_ALARMS
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [NUM_ALARMS-1:0] alarm_live,
    input wire evpc_cal_t cal_in,
    output logic alarm_pin_a,
    output logic alarm_pin_b,
    output logic irq
);
    evpc_state_t st;
    evpc_state_t next_st;
    logic [NUM_ALARMS-1:0] flags;
    logic [NUM_ALARMS-1:0] flag_rise;
    logic [EVPC_STAT_W-1:0] stat_clr;
    logic [EVPC_STAT_W-1:0] stat_set;
    logic wr_en;
    logic rd_req;
    logic [EVPC_CAL_W-1:0] cal_after_write;

    // address decode; only whole-word accesses reach a register
    function automatic evpc_sel_t reg_decode(
        input logic [31:0] addr,
        input logic [2:0] size
    );
        evpc_sel_t sel;
        sel = EVPC_SEL_NONE;
        if (addr[31:EVPC_OFF_W] == '0 && size == EVPC_HSIZE_WORD) begin
            case (addr[EVPC_OFF_W-1:0])
                EVPC_OFF_EVENT: begin
                    sel = EVPC_SEL_EVENT;
                end
                EVPC_OFF_STAT: begin
                    sel = EVPC_SEL_STAT;
                end
                EVPC_OFF_MASK: begin
                    sel = EVPC_SEL_MASK;
                end
                EVPC_OFF_LIVE: begin
                    sel = EVPC_SEL_LIVE;
                end
                default: begin
                    sel = EVPC_SEL_NONE;
                end
            endcase
        end
        return sel;
    endfunction

    // pin level; manual bit only counts while nothing is mapped
    function automatic logic pin_level(
        input logic [NUM_ALARMS-1:0] map,
        input logic [NUM_ALARMS-1:0] flg,
        input logic manual
    );
        logic lvl;
        lvl = manual;
        if (|map) begin
            lvl = |(map & flg);
        end
        return lvl;
    endfunction

    // gather the event register from the stored fields
    function automatic logic [31:0] pack_event(input evpc_state_t s);
        logic [31:0] word;
        word = EVPC_EVENT_RESET;
        word[EVPC_CAL_LSB +: EVPC_CAL_W] = s.cal_fail;
        word[EVPC_MAN_B_BIT] = s.man_b;
        word[EVPC_MAN_A_BIT] = s.man_a;
        for (int i = 0; i < NUM_ALARMS; i++) begin
            word[EVPC_MAP_A_POS[i]] = s.map_a[i];
            word[EVPC_MAP_B_POS[i]] = s.map_b[i];
            word[EVPC_CLR_POS[i]] = s.clr[i];
            word[EVPC_HOLD_POS[i]] = s.hold[i];
            word[EVPC_SIM_POS[i]] = s.sim[i];
        end
        return word;
    endfunction

    // read multiplexer; unmapped addresses read as zero
    function automatic logic [31:0] read_mux(
        input evpc_state_t s,
        input evpc_sel_t sel,
        input logic [NUM_ALARMS-1:0] flg,
        input logic [NUM_ALARMS-1:0] raw
    );
        logic [31:0] word;
        word = '0;
        case (sel)
            EVPC_SEL_EVENT: begin
                word = pack_event(s);
            end
            EVPC_SEL_STAT: begin
                word[EVPC_STAT_W-1:0] = s.stat;
            end
            EVPC_SEL_MASK: begin
                word[EVPC_STAT_W-1:0] = s.mask;
            end
            EVPC_SEL_LIVE: begin
                word[NUM_ALARMS-1:0] = flg;
                word[EVPC_LIVE_RAW_LSB +: NUM_ALARMS] = raw;
                word[EVPC_LIVE_PIN_A] = s.pin_a;
                word[EVPC_LIVE_PIN_B] = s.pin_b;
            end
            default: begin
                word = '0;
            end
        endcase
        return word;
    endfunction

    // one flag cell per alarm
    generate
        for (genvar g = 0; g < NUM_ALARMS; g++) begin : g_alarm
            evpc_alarm_cell u_cell (
                .sys_clk(sys_clk),
                .rst_n(rst_n),
                .live(alarm_live[g]),
                .simulate(st.sim[g]),
                .hold(st.hold[g]),
                .clear(st.clr[g]),
                .flag(flags[g])
            );
        end
    endgenerate

    // a write lands in the data phase, one cycle after its address
    assign wr_en = st.ph_valid & st.ph_write;
    assign rd_req = hsel & hready & htrans[EVPC_HTRANS_ACTIVE_BIT] & ~hwrite;
    assign flag_rise = flags & ~st.flag_q;

    // calibration field after any software write of this cycle
    always_comb begin
        cal_after_write = st.cal_fail;
        if (wr_en && st.ph_sel == EVPC_SEL_EVENT) begin
            cal_after_write = hwdata[EVPC_CAL_LSB +: EVPC_CAL_W];
        end
    end

    // hardware events that set sticky status bits
    always_comb begin
        stat_set = '0;
        stat_set[NUM_ALARMS-1:0] = flag_rise;
        stat_set[EVPC_ST_CAL_FAIL] = cal_in.done & ~cal_in.pass;
        stat_set[EVPC_ST_CAL_PASS] = cal_in.done & cal_in.pass;
    end

    // write-one-to-clear mask for the status register
    always_comb begin
        stat_clr = '0;
        if (wr_en && st.ph_sel == EVPC_SEL_STAT) begin
            stat_clr = hwdata[EVPC_STAT_W-1:0];
        end
    end

    // next state of the whole block
    always_comb begin
        next_st = st;

        // software writes to the configuration fields
        if (wr_en) begin
            case (st.ph_sel)
                EVPC_SEL_EVENT: begin
                    next_st.man_b = hwdata[EVPC_MAN_B_BIT];
                    next_st.man_a = hwdata[EVPC_MAN_A_BIT];
                    for (int i = 0; i < NUM_ALARMS; i++) begin
                        next_st.map_b[i] = hwdata[EVPC_MAP_B_POS[i]];
                        next_st.map_a[i] = hwdata[EVPC_MAP_A_POS[i]];
                        next_st.clr[i] = hwdata[EVPC_CLR_POS[i]];
                        next_st.hold[i] = hwdata[EVPC_HOLD_POS[i]];
                        next_st.sim[i] = hwdata[EVPC_SIM_POS[i]];
                    end
                end
                EVPC_SEL_MASK: begin
                    next_st.mask = hwdata[EVPC_STAT_W-1:0];
                end
                default: begin
                    next_st.mask = st.mask;
                end
            endcase
        end

        // calibration result is applied on top of a same-cycle software write of the top byte
        next_st.cal_fail = cal_after_write;
        if (cal_in.done) begin
            if (cal_in.pass) begin
                next_st.cal_fail = cal_after_write & ~cal_in.chans;
            end else begin
                next_st.cal_fail = cal_after_write | cal_in.chans;
            end
        end

        // sticky status, a set in the clear cycle survives
        next_st.stat = (st.stat & ~stat_clr) | stat_set;
        next_st.flag_q = flags;
        next_st.irq = |(next_st.stat & next_st.mask);

        // pins follow the new routing from the next edge on
        next_st.pin_a = pin_level(next_st.map_a, flags, next_st.man_a);
        next_st.pin_b = pin_level(next_st.map_b, flags, next_st.man_b);

        // address phase capture; the slave never inserts wait states
        next_st.ph_valid = hsel & hready & htrans[EVPC_HTRANS_ACTIVE_BIT];
        next_st.ph_write = hwrite;
        next_st.ph_sel = reg_decode(haddr, hsize);

        // read data from the updated copy so write-then-read is coherent
        next_st.rdata = '0;
        if (rd_req) begin
            next_st.rdata = read_mux(next_st, next_st.ph_sel, flags, alarm_live);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= evpc_state_t'('0);
        end else begin
            st <= next_st;
        end
    end

    // read data, pins and irq straight from flip-flops; hreadyout and hresp are constants
    assign hrdata = st.rdata;
    assign alarm_pin_a = st.pin_a;
    assign alarm_pin_b = st.pin_b;
    assign irq = st.irq;
    assign hreadyout = EVPC_HREADY_NOWAIT;
    assign hresp = EVPC_HRESP_OKAY;
endmodule

// ### tb/evpc_event_ctrl_assertions.sv
// checker: bus, event pin and interrupt relations at the block's ports
`timescale 1ns/1ps
module evpc_event_ctrl_chk
    import evpc_pkg::*;
#(
    parameter int NUM_ALARMS = EVPC_NUM_ALARMS
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic [NUM_ALARMS-1:0] alarm_live,
    input wire evpc_cal_t cal_in,
    input wire logic alarm_pin_a,
    input wire logic alarm_pin_b,
    input wire logic irq
);
    logic ph_rd, ph_wr, ph_ev, ph_mk, ph_nc;
    logic [31:0] ev_sh;
    logic [EVPC_STAT_W-1:0] mk_sh;
    logic [7:0] cal_base;
    wire logic ok = hsel & hready & htrans[1] & (hsize == EVPC_HSIZE_WORD) & ~|haddr[31:8];
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // a calibration pulse lands on top of a same-edge write of the top byte
    assign cal_base = (ph_wr & ph_ev) ? hwdata[31:24] : ev_sh[31:24];
    // shadow copies of the event and mask registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            {ph_rd, ph_wr, ph_ev, ph_mk, ph_nc} <= 5'h00;
            ev_sh <= 32'h0000_0000;
            mk_sh <= '0;
        end else begin
            ph_rd <= hsel & hready & htrans[1] & ~hwrite;
            ph_wr <= ok & hwrite;
            ph_ev <= ok & (haddr[7:0] == EVPC_OFF_EVENT);
            ph_mk <= ok & (haddr[7:0] == EVPC_OFF_MASK);
            ph_nc <= ~cal_in.done;
            if (ph_wr & ph_ev) ev_sh[23:0] <= hwdata[23:0] & 24'hFF_CFFF;
            if (cal_in.done && cal_in.pass) begin
                ev_sh[31:24] <= cal_base & ~cal_in.chans;
            end else if (cal_in.done) begin
                ev_sh[31:24] <= cal_base | cal_in.chans;
            end else begin
                ev_sh[31:24] <= cal_base;
            end
            if (ph_wr & ph_mk) mk_sh <= hwdata[EVPC_STAT_W-1:0];
        end
    end
    // same alarm mapped and live over three samples
    sequence hit_a;
        ((ev_sh[19:16] & alarm_live) != 4'h0 && $stable(ev_sh[19:16] & alarm_live)) [*3];
    endsequence
    sequence hit_b;
        ((ev_sh[23:20] & alarm_live) != 4'h0 && $stable(ev_sh[23:20] & alarm_live)) [*3];
    endsequence
    a_bus_okay: assert property (hreadyout == EVPC_HREADY_NOWAIT && hresp == EVPC_HRESP_OKAY)
        else $error("bus answer not zero-wait okay");
    a_rdata_idle: assert property (!ph_rd |-> hrdata == 32'h0)
        else $error("read data outside a read data phase");
    a_event_readback: assert property (ph_rd && ph_ev && ph_nc |-> hrdata == ev_sh)
        else $error("event register read differs from shadow");
    a_pin_a_manual: assert property (ev_sh[19:16] == 4'h0 |-> alarm_pin_a == ev_sh[14])
        else $error("pin a not at manual level");
    a_pin_b_manual: assert property (ev_sh[23:20] == 4'h0 |-> alarm_pin_b == ev_sh[15])
        else $error("pin b not at manual level");
    a_pin_a_alarm: assert property (hit_a |-> alarm_pin_a)
        else $error("pin a low with mapped alarm");
    a_pin_b_alarm: assert property (hit_b |-> alarm_pin_b)
        else $error("pin b low with mapped alarm");
    a_irq_masked: assert property (irq |-> (mk_sh | $past(mk_sh)) != '0)
        else $error("interrupt with every source masked");
endmodule

// ### tb/evpc_pin_sink.sv
// load-control side: counts rising edges seen on the two event pins
`timescale 1ns/1ps
module evpc_pin_sink (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic pin_a,
    input wire logic pin_b,
    output logic [7:0] rise_a,
    output logic [7:0] rise_b
);
    logic [1:0] last;
    // edge-sensitive input: a level held high counts once
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            last <= 2'b00;
            rise_a <= 8'h00;
            rise_b <= 8'h00;
        end else begin
            last <= {pin_b, pin_a};
            rise_a <= rise_a + 8'(pin_a & ~last[0]);
            rise_b <= rise_b + 8'(pin_b & ~last[1]);
        end
    end
endmodule

// ### tb/event_pin_and_cal_status_tb_top.sv
// testbench: register bus, event pins, latching, interrupt and calibration flags
`timescale 1ns/1ps
module event_pin_and_cal_status_tb_top;
    import evpc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic rd_ph = 1'b0;
    logic [31:0] haddr = '0;
    logic [31:0] hwdata = '0;
    logic [1:0] htrans = '0;
    logic [2:0] hsize = EVPC_HSIZE_WORD;
    logic [3:0] alarm_live = '0;
    evpc_cal_t cal_in = '0;
    logic hready, hresp, alarm_pin_a, alarm_pin_b, irq;
    logic [31:0] hrdata, r, m;
    logic [7:0] rise_a, rise_b, na, nb;
    logic [31:0] exp_q [$];
    int bad_count = 0;
    int tests_run = 0;
    always #50 sys_clk = ~sys_clk;
    evpc_event_ctrl evpc_event_ctrl_i (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
        .alarm_live(alarm_live), .cal_in(cal_in), .alarm_pin_a(alarm_pin_a),
        .alarm_pin_b(alarm_pin_b), .irq(irq));
    evpc_pin_sink evpc_pin_sink_i (.sys_clk(sys_clk), .rst_n(rst_n), .pin_a(alarm_pin_a),
        .pin_b(alarm_pin_b), .rise_a(rise_a), .rise_b(rise_b));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // one single transfer; waits on hready, no fixed latency assumed
    task automatic bus(input logic w, input logic [EVPC_OFF_W-1:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= 32'(a);
        hwrite <= w;
        do @(posedge sys_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        rd_ph <= !w;
        do @(posedge sys_clk); while (hready !== 1'b1);
        rd_ph <= 1'b0;
    endtask
    task automatic rd(input logic [EVPC_OFF_W-1:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic pins(input logic [1:0] e);
        @(posedge sys_clk);
        chk({30'h0, alarm_pin_b, alarm_pin_a}, {30'h0, e});
    endtask
    // read data taken at the edge closing the data phase
    always @(posedge sys_clk) if (rd_ph) chk(hrdata, exp_q.pop_front());
    initial begin
        void'($urandom(32'h67536f04));
        cyc(20);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        rd(EVPC_OFF_EVENT, 32'h0);
        rd(8'h10, 32'h0);
        r = $urandom & 32'hFFFF_FFF0;
        bus(1'b1, EVPC_OFF_EVENT, r);
        rd(EVPC_OFF_EVENT, r & 32'hFFFF_CFFF);
        na = rise_a;
        nb = rise_b;
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, EVPC_OFF_EVENT, 32'(k) << EVPC_MAN_A_BIT);
            pins(2'(k));
        end
        @(posedge sys_clk);
        chk(32'(rise_a - na), 32'h2);
        chk(32'(rise_b - nb), 32'h1);
        // mapped alarm overrides a high manual level
        for (int i = 0; i < 4; i++) begin
            for (int p = 0; p < 2; p++) begin
                m = 32'h0000_C000 | (32'h1 << (p ? EVPC_MAP_B_POS[i] : EVPC_MAP_A_POS[i]));
                bus(1'b1, EVPC_OFF_EVENT, m);
                alarm_live <= 4'h1 << i;
                cyc(2);
                pins(2'b11);
                alarm_live <= 4'h1 << ((i + 1) % 4);
                cyc(2);
                pins(p ? 2'b01 : 2'b10);
            end
        end
        // latch a short pulse, clear it, then simulate it
        for (int i = 0; i < 4; i++) begin
            m = (32'h1 << EVPC_MAP_A_POS[i]) | (32'h1 << EVPC_HOLD_POS[i]);
            bus(1'b1, EVPC_OFF_EVENT, m);
            alarm_live <= 4'h1 << i;
            cyc(1);
            alarm_live <= 4'h0;
            cyc(3);
            pins(2'b01);
            rd(EVPC_OFF_LIVE, (32'h1 << i) | (32'h1 << EVPC_LIVE_PIN_A));
            bus(1'b1, EVPC_OFF_EVENT, m | (32'h1 << EVPC_CLR_POS[i]));
            bus(1'b1, EVPC_OFF_EVENT, m);
            pins(2'b00);
            bus(1'b1, EVPC_OFF_EVENT, (32'h1 << EVPC_MAP_A_POS[i]) | (32'h1 << EVPC_SIM_POS[i]));
            cyc(2);
            pins(2'b01);
        end
        // interrupt: raised while masked, unmasked, then cleared
        bus(1'b1, EVPC_OFF_EVENT, 32'h0);
        bus(1'b1, EVPC_OFF_STAT, 32'h0000_003F);
        alarm_live <= 4'h1;
        cyc(3);
        alarm_live <= 4'h0;
        rd(EVPC_OFF_STAT, 32'h1);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, EVPC_OFF_MASK, 32'h1);
        rd(EVPC_OFF_MASK, 32'h1);
        cyc(2);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, EVPC_OFF_STAT, 32'h1);
        cyc(2);
        chk({31'h0, irq}, 32'h0);
        // random failures, then a partial pass
        r = $urandom;
        m = $urandom;
        cal_in <= {1'b1, 1'b0, r[7:0]};
        @(posedge sys_clk);
        cal_in <= {1'b1, 1'b1, m[7:0]};
        @(posedge sys_clk);
        cal_in <= '0;
        rd(EVPC_OFF_EVENT, {r[7:0] & ~m[7:0], 24'h0});
        rd(EVPC_OFF_STAT, 32'h30);
        close_out();
    end
    initial begin
        #2_000_000;
        bad_count++;
        close_out();
    end
endmodule
bind evpc_event_ctrl evpc_event_ctrl_chk #(.NUM_ALARMS(NUM_ALARMS)) chk_i (.sys_clk(sys_clk),
    .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .alarm_live(alarm_live), .cal_in(cal_in), .alarm_pin_a(alarm_pin_a),
    .alarm_pin_b(alarm_pin_b), .irq(irq));
